// >>> hw/osc_ctrl.v
// RC and crystal oscillator control with an AXI4-Lite register slave.
// Assumes rc_clk_in and xtal_clk_in are sampled levels synchronous to ref_clk, and that
// the analog oscillators obey the run, bias and trim outputs.
`timescale 1ns/1ns
`include "osc_ctrl_defs.vh"

// Contract
// - Power-on, reset pin and sleep exit turn RC on and select it.
// - The RC enable bit gates the oscillator and its clock output.
// - Clearing the RC enable bit stops the RC oscillator.
// - Sleep disables the RC oscillator regardless of its enable bit.
// - Bias-keep holds RC bias on while the oscillator is disabled or asleep; cold reset turns the bias off.
// - Range bit picks the low or high RC frequency range.
// - Setting the range bit multiplies RC frequency by ten.
// - Coarse trim scales RC frequency by field value plus one.
// - Each fine trim step raises RC frequency about 1.4 percent.
// - The crystal oscillator runs from a 32768 Hz crystal.
// - The first 32768 crystal cycles never reach the clock output.
// - Reset, reset pin and sleep clear crystal enable and set warming flag.
// - Warming flag clears after 32768 crystal cycles once started.
// - Clearing the crystal enable bit stops the crystal oscillator.
// - Entering sleep stops the crystal oscillator.
// - Bias-keep resets to one on cold reset.
// - Coarse trim is four bits resetting to one; fine trim six bits resetting to zero.
// - Warming flag is read-only and set for 32768 crystal cycles after enable.
module osc_ctrl #(
   parameter WARMUP_CYCLES = `CRYSTAL_WARMUP_CYCLES
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        external_reset_pin_n,
   input  wire        sleep_mode,
   input  wire        rc_clk_in,
   input  wire        xtal_clk_in,
   // AXI4-Lite slave.
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Oscillator controls and gated clocks.
   output wire        rc_osc_run,
   output wire        rc_bias_on,
   output wire        rc_range_select,
   output wire [3:0]  rc_coarse_trim,
   output wire [5:0]  rc_fine_trim,
   output wire        crystal_osc_run,
   output wire        crystal_warming_flag,
   output wire        rc_clk_gated,
   output wire        xtal_clk_gated,
   output wire        rc_forced_select
);

   // Gate for an oscillator clock: the gate may only move while the clock is low, so outside
   // sleep and cold reset, which clear it at once, the gated output never sees a shortened high phase.
   function gate_next;
      input cur_gate;
      input want_gate;
      input clk_level;
      begin
         gate_next = clk_level ? cur_gate : want_gate;
      end
   endfunction

   // A register is hit when the whole byte address equals its offset; aliases are refused.
   function addr_hit;
      input [31:0] addr;
      input [3:0]  reg_addr;
      begin
         addr_hit = (addr[31:4] == 28'h0000000) && (addr[3:0] == reg_addr);
      end
   endfunction

   function addr_mapped;
      input [31:0] addr;
      begin
         addr_mapped = addr_hit(addr, `CLOCK_SOURCE_CONTROL_REG_ADDR) ||
                       addr_hit(addr, `RC_TRIM_RANGE_COARSE_REG_ADDR) ||
                       addr_hit(addr, `RC_TRIM_FINE_REG_ADDR) ||
                       addr_hit(addr, `OSC_STATUS_REG_ADDR);
      end
   endfunction

   // Control registers.
   reg        rc_osc_on_ff;
   reg        crystal_osc_on_ff;
   reg        rc_bias_keep_ff;
   reg        rc_range_select_ff;
   reg [3:0]  rc_coarse_trim_ff;
   reg [5:0]  rc_fine_trim_ff;
   reg        rc_forced_ff;

   // Output and gating registers.
   reg        rc_run_ff;
   reg        rc_bias_out_ff;
   reg        crystal_run_ff;
   reg        rc_gate_ff;
   reg        xtal_gate_ff;
   reg        rc_clk_out_ff;
   reg        xtal_clk_out_ff;
   reg        xtal_prev_ff;
   reg        sleep_seen_ff;

   // Bus registers.
   reg        awready_ff;
   reg        wready_ff;
   reg        bvalid_ff;
   reg [1:0]  bresp_ff;
   reg        aw_held_ff;
   reg        w_held_ff;
   reg [31:0] awaddr_ff;
   reg [31:0] wdata_ff;
   reg [3:0]  wstrb_ff;
   reg        arready_ff;
   reg        rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0]  rresp_ff;

   wire       cold_reset;
   wire       sleep_reset;
   wire       sleep_exit;
   wire       wr_fire;
   wire       wr_lane0;
   wire       xtal_edge;
   wire       warming;
   wire       rc_want;
   wire       xtal_want;
   reg [31:0] nxt_rdata;

   // The reset pin acts as a cold reset alongside power-on; sleep also holds the
   // sleep-domain bits at their reset values for as long as it lasts.
   assign cold_reset  = !rst_n || !external_reset_pin_n;
   assign sleep_reset = cold_reset || sleep_mode;
   assign sleep_exit  = sleep_seen_ff && !sleep_mode;

   assign wr_fire  = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_lane0 = wr_fire && wstrb_ff[0] && !sleep_reset;
   assign xtal_edge = xtal_clk_in && !xtal_prev_ff;

   // Sleep-domain bits: clock source enables.
   always @(posedge ref_clk) begin
      if (sleep_reset) begin
         rc_osc_on_ff      <= `RC_OSC_ON_RST;
         crystal_osc_on_ff <= `CRYSTAL_OSC_ON_RST;
      end else if (wr_lane0 && addr_hit(awaddr_ff, `CLOCK_SOURCE_CONTROL_REG_ADDR)) begin
         rc_osc_on_ff      <= wdata_ff[`RC_OSC_ON_BIT];
         crystal_osc_on_ff <= wdata_ff[`CRYSTAL_OSC_ON_BIT];
      end
   end

   // Cold-domain bits: bias and trims survive sleep.
   always @(posedge ref_clk) begin
      if (cold_reset) begin
         rc_bias_keep_ff    <= `RC_BIAS_KEEP_RST;
         rc_range_select_ff <= `RC_RANGE_SELECT_RST;
         rc_coarse_trim_ff  <= `RC_COARSE_TRIM_RST;
         rc_fine_trim_ff    <= `RC_FINE_TRIM_RST;
      end else if (wr_lane0) begin
         if (addr_hit(awaddr_ff, `CLOCK_SOURCE_CONTROL_REG_ADDR)) begin
            rc_bias_keep_ff <= wdata_ff[`RC_BIAS_KEEP_BIT];
         end
         if (addr_hit(awaddr_ff, `RC_TRIM_RANGE_COARSE_REG_ADDR)) begin
            rc_range_select_ff <= wdata_ff[`RC_RANGE_SELECT_BIT];
            rc_coarse_trim_ff  <= wdata_ff[`RC_COARSE_TRIM_MSB:0];
         end
         if (addr_hit(awaddr_ff, `RC_TRIM_FINE_REG_ADDR)) begin
            rc_fine_trim_ff <= wdata_ff[`RC_FINE_TRIM_MSB:0];
         end
      end
   end

   // RC stays the CPU source after reset or sleep exit until software next writes the
   // clock source control register.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         sleep_seen_ff <= 1'b0;
         rc_forced_ff  <= 1'b1;
      end else begin
         sleep_seen_ff <= sleep_mode;
         if (cold_reset || sleep_mode || sleep_exit) begin
            rc_forced_ff <= 1'b1;
         end else if (wr_lane0 && addr_hit(awaddr_ff, `CLOCK_SOURCE_CONTROL_REG_ADDR)) begin
            rc_forced_ff <= 1'b0;
         end
      end
   end

   osc_warmup #(
      .WARMUP_CYCLES (WARMUP_CYCLES)
   ) u_warmup (
      .ref_clk   (ref_clk),
      .hold      (sleep_reset),
      .run       (crystal_osc_on_ff),
      .xtal_edge (xtal_edge),
      .warming   (warming)
   );

   // The crystal clock passes only after warm-up, hiding its unsettled first cycles.
   assign rc_want   = rc_osc_on_ff && !sleep_mode;
   assign xtal_want = crystal_osc_on_ff && !sleep_mode && !warming;

   always @(posedge ref_clk) begin
      if (sleep_reset) begin
         rc_run_ff       <= 1'b0;
         rc_bias_out_ff  <= 1'b0;
         crystal_run_ff  <= 1'b0;
         rc_gate_ff      <= 1'b0;
         xtal_gate_ff    <= 1'b0;
         rc_clk_out_ff   <= 1'b0;
         xtal_clk_out_ff <= 1'b0;
         xtal_prev_ff    <= 1'b0;
      end else begin
         rc_run_ff       <= rc_want;
         rc_bias_out_ff  <= rc_want || rc_bias_keep_ff;
         crystal_run_ff  <= crystal_osc_on_ff;
         rc_gate_ff      <= gate_next(rc_gate_ff, rc_want, rc_clk_in);
         xtal_gate_ff    <= gate_next(xtal_gate_ff, xtal_want, xtal_clk_in);
         rc_clk_out_ff   <= rc_clk_in && gate_next(rc_gate_ff, rc_want, rc_clk_in);
         xtal_clk_out_ff <= xtal_clk_in && gate_next(xtal_gate_ff, xtal_want, xtal_clk_in);
         xtal_prev_ff    <= xtal_clk_in;
      end
   end

   // Bias stays on through sleep only as far as the cold-domain bit allows, and is off during cold reset;
   // the restart then costs a few microseconds rather than tens.
   wire bias_sleep = sleep_mode && rc_bias_keep_ff && !cold_reset;

   // Write channel: address and data are caught in either order, answered when both are in.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `AXI_RESP_OKAY;
         awaddr_ff  <= 32'h00000000;
         wdata_ff   <= 32'h00000000;
         wstrb_ff   <= 4'h0;
      end else begin
         if (awready_ff && s_axi_awvalid) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (wready_ff && s_axi_wvalid) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= addr_mapped(awaddr_ff) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   // Read data mux; unused and reserved bits read as zero.
   always @* begin
      nxt_rdata = 32'h00000000;
      if (addr_hit(s_axi_araddr, `CLOCK_SOURCE_CONTROL_REG_ADDR)) begin
         nxt_rdata[`RC_OSC_ON_BIT]            = rc_osc_on_ff;
         nxt_rdata[`CRYSTAL_OSC_ON_BIT]       = crystal_osc_on_ff;
         nxt_rdata[`CRYSTAL_WARMING_FLAG_BIT] = warming;
         nxt_rdata[`RC_BIAS_KEEP_BIT]         = rc_bias_keep_ff;
      end else if (addr_hit(s_axi_araddr, `RC_TRIM_RANGE_COARSE_REG_ADDR)) begin
         nxt_rdata[`RC_RANGE_SELECT_BIT]     = rc_range_select_ff;
         nxt_rdata[`RC_COARSE_TRIM_MSB:0]    = rc_coarse_trim_ff;
      end else if (addr_hit(s_axi_araddr, `RC_TRIM_FINE_REG_ADDR)) begin
         nxt_rdata[`RC_FINE_TRIM_MSB:0] = rc_fine_trim_ff;
      end else if (addr_hit(s_axi_araddr, `OSC_STATUS_REG_ADDR)) begin
         nxt_rdata[`STAT_RC_RUN_BIT]      = rc_run_ff;
         nxt_rdata[`STAT_CRYSTAL_RUN_BIT] = crystal_run_ff;
         nxt_rdata[`STAT_SLEEP_BIT]       = sleep_mode;
         nxt_rdata[`STAT_RC_FORCED_BIT]   = rc_forced_ff;
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= `AXI_RESP_OKAY;
      end else begin
         if (arready_ff && s_axi_arvalid) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= addr_mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end
         if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

   // Trim outputs come straight from their registers; the analog core applies the range
   // factor, the coarse multiplier and the compounding fine step.
   reg rc_bias_pin_ff;
   always @(posedge ref_clk) begin
      if (cold_reset) begin
         rc_bias_pin_ff <= 1'b0;
      end else begin
         rc_bias_pin_ff <= rc_bias_out_ff || bias_sleep;
      end
   end

   reg crystal_warming_out_ff;
   always @(posedge ref_clk) begin
      if (sleep_reset) begin
         crystal_warming_out_ff <= 1'b1;
      end else begin
         crystal_warming_out_ff <= warming;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   assign rc_osc_run           = rc_run_ff;
   assign rc_bias_on           = rc_bias_pin_ff;
   assign rc_range_select      = rc_range_select_ff;
   assign rc_coarse_trim       = rc_coarse_trim_ff;
   assign rc_fine_trim         = rc_fine_trim_ff;
   assign crystal_osc_run      = crystal_run_ff;
   assign crystal_warming_flag = crystal_warming_out_ff;
   assign rc_clk_gated         = rc_clk_out_ff;
   assign xtal_clk_gated       = xtal_clk_out_ff;
   assign rc_forced_select     = rc_forced_ff;

endmodule

// >>> shared/osc_ctrl_defs.vh
// Constants for the RC and crystal oscillator control block.
// Assumes a 32-bit AXI4-Lite register bus; each register sits in the low byte of its own word.
`ifndef OSC_CTRL_DEFS_VH
`define OSC_CTRL_DEFS_VH

// Register byte addresses.
`define CLOCK_SOURCE_CONTROL_REG_ADDR 4'h0
`define RC_TRIM_RANGE_COARSE_REG_ADDR 4'h4
`define RC_TRIM_FINE_REG_ADDR         4'h8
`define OSC_STATUS_REG_ADDR           4'hc

// Clock source control register fields.
`define RC_OSC_ON_BIT            0
`define CRYSTAL_OSC_ON_BIT       1
`define CRYSTAL_WARMING_FLAG_BIT 3
`define RC_BIAS_KEEP_BIT         4

// Trim register fields.
`define RC_RANGE_SELECT_BIT 4
`define RC_COARSE_TRIM_MSB  3
`define RC_FINE_TRIM_MSB    5

// Status register fields.
`define STAT_RC_RUN_BIT      0
`define STAT_CRYSTAL_RUN_BIT 1
`define STAT_SLEEP_BIT       2
`define STAT_RC_FORCED_BIT   3

// Reset values.
`define RC_OSC_ON_RST       1'h1
`define CRYSTAL_OSC_ON_RST  1'h0
`define RC_BIAS_KEEP_RST    1'h1
`define RC_RANGE_SELECT_RST 1'h0
`define RC_COARSE_TRIM_RST  4'h1
`define RC_FINE_TRIM_RST    6'h00

// Analog figures that the trim outputs steer.
`define RC_LOW_RANGE_MIN_HZ  50000
`define RC_RANGE_SPLIT_HZ    500000
`define RC_HIGH_RANGE_MAX_HZ 5000000
`define RC_RANGE_FACTOR      10
`define CRYSTAL_NOMINAL_HZ   32768

// Crystal warm-up length in crystal cycles.
`define CRYSTAL_WARMUP_CYCLES 32768
`define WARMUP_CNT_W          16

// AXI responses.
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// >>> hw/osc_warmup.v
// Crystal warm-up counter: holds the warming flag while the first crystal cycles run.
// Assumes xtal_edge is a one-cycle pulse per crystal rising edge, already in the ref_clk domain.
`timescale 1ns/1ns
`include "osc_ctrl_defs.vh"

module osc_warmup #(
   parameter WARMUP_CYCLES = `CRYSTAL_WARMUP_CYCLES
) (
   input  wire ref_clk,
   input  wire hold,
   input  wire run,
   input  wire xtal_edge,
   output wire warming
);

   localparam integer             LAST_CYCLE_INT = WARMUP_CYCLES - 1;
   localparam [`WARMUP_CNT_W-1:0] LAST_CYCLE     = LAST_CYCLE_INT[`WARMUP_CNT_W-1:0];

   reg [`WARMUP_CNT_W-1:0] count_ff;
   reg                     warming_ff;

   // A stopped crystal restarts its warm-up from zero, since its phase and amplitude are lost.
   always @(posedge ref_clk) begin
      if (hold || !run) begin
         count_ff   <= {`WARMUP_CNT_W{1'b0}};
         warming_ff <= 1'b1;
      end else if (warming_ff && xtal_edge) begin
         if (count_ff == LAST_CYCLE) begin
            warming_ff <= 1'b0;
         end
         count_ff <= count_ff + 1'b1;
      end
   end

   assign warming = warming_ff;

endmodule

// >>> test/osc_ctrl_monitor.sv
// Checker for the oscillator control block, bound to its top module.
// Assumes the crystal input is a level sampled in the ref_clk domain, as the block assumes.
`timescale 1ns/1ns
module osc_ctrl_monitor #(
   parameter WARMUP_CYCLES = 32768
) (
   input wire ref_clk,
   input wire rst_n,
   input wire external_reset_pin_n,
   input wire sleep_mode,
   input wire xtal_clk_in,
   input wire rc_osc_run,
   input wire crystal_osc_run,
   input wire crystal_warming_flag,
   input wire rc_clk_gated,
   input wire xtal_clk_gated,
   input wire rc_forced_select
);
   reg        xtal_prev_ff;
   reg [16:0] edge_cnt_ff;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Edges count only while the crystal runs, so a restart starts the tally again from zero.
   always @(posedge ref_clk) begin
      xtal_prev_ff <= xtal_clk_in;
      if (!rst_n || !crystal_osc_run)
         edge_cnt_ff <= 17'h00000;
      else if (xtal_clk_in && !xtal_prev_ff && edge_cnt_ff != 17'h1ffff)
         edge_cnt_ff <= edge_cnt_ff + 17'h00001;
   end
   sequence s_restart; ($fell(sleep_mode) || $rose(rst_n) || $rose(external_reset_pin_n)) && !sleep_mode && external_reset_pin_n; endsequence
   sequence s_rc_selected; ##[0:2] (rc_osc_run && rc_forced_select); endsequence
   sequence s_warm_done; $fell(crystal_warming_flag); endsequence
   property p_sleep_rc_off; sleep_mode |=> !rc_osc_run; endproperty
   property p_sleep_xtal_off; sleep_mode |=> !crystal_osc_run; endproperty
   property p_sleep_warm; sleep_mode [*2] |=> crystal_warming_flag; endproperty
   property p_pin_cold; !external_reset_pin_n [*2] |=> crystal_warming_flag && !crystal_osc_run; endproperty
   property p_restart_rc; s_restart |-> s_rc_selected; endproperty
   property p_xtal_masked; $rose(xtal_clk_gated) |-> !$past(crystal_warming_flag); endproperty
   property p_xtal_whole; $fell(xtal_clk_gated) && !$past(sleep_mode) && $past(external_reset_pin_n) |-> !$past(xtal_clk_in); endproperty
   property p_rc_gate; !rc_osc_run [*4] |-> !rc_clk_gated; endproperty
   property p_warm_fall; s_warm_done |-> edge_cnt_ff >= WARMUP_CYCLES - 1 && edge_cnt_ff <= WARMUP_CYCLES + 1; endproperty
   property p_warm_bound; edge_cnt_ff >= WARMUP_CYCLES + 2 |-> !crystal_warming_flag; endproperty
   a_sleep_rc_off: assert property (p_sleep_rc_off) else $error("rc runs in sleep");
   a_sleep_xtal_off: assert property (p_sleep_xtal_off) else $error("crystal runs in sleep");
   a_sleep_warm: assert property (p_sleep_warm) else $error("warming clear in sleep");
   a_pin_cold: assert property (p_pin_cold) else $error("reset pin left crystal on");
   a_restart_rc: assert property (p_restart_rc) else $error("rc not selected on restart");
   a_xtal_masked: assert property (p_xtal_masked) else $error("crystal pulse while warming");
   a_xtal_whole: assert property (p_xtal_whole) else $error("crystal pulse cut short");
   a_rc_gate: assert property (p_rc_gate) else $error("rc clock passes while off");
   a_warm_fall: assert property (p_warm_fall) else $error("warming ended at wrong count");
   a_warm_bound: assert property (p_warm_bound) else $error("warming held too long");
endmodule
bind osc_ctrl osc_ctrl_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES)) mon (.ref_clk, .rst_n, .external_reset_pin_n,
   .sleep_mode, .xtal_clk_in, .rc_osc_run, .crystal_osc_run, .crystal_warming_flag, .rc_clk_gated,
   .xtal_clk_gated, .rc_forced_select);

// >>> test/rc_and_crystal_oscillator_control_tb.sv
// Self-checking bench for the oscillator control block.
// Assumes osc_ctrl with its checker bound; every input is driven just after the rising edge.
`timescale 1ns/1ns
module rc_and_crystal_oscillator_control_tb;
   localparam W = 8;
   reg         ref_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         external_reset_pin_n = 1'b1;
   reg         sleep_mode = 1'b0;
   reg         rc_clk_in = 1'b0;
   reg         xtal_clk_in = 1'b0;
   reg  [2:0]  div_ff = 3'h0;
   reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        rc_osc_run, rc_bias_on, rc_range_select, crystal_osc_run, crystal_warming_flag;
   wire        rc_clk_gated, xtal_clk_gated, rc_forced_select;
   wire [3:0]  rc_coarse_trim;
   wire [5:0]  rc_fine_trim;
   integer     num_checks = 0, miscompares = 0, cyc = 0;
   osc_ctrl #(.WARMUP_CYCLES(W)) dut (.ref_clk, .rst_n, .external_reset_pin_n, .sleep_mode, .rc_clk_in,
      .xtal_clk_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_osc_run, .rc_bias_on, .rc_range_select,
      .rc_coarse_trim, .rc_fine_trim, .crystal_osc_run, .crystal_warming_flag, .rc_clk_gated, .xtal_clk_gated,
      .rc_forced_select);
   always #5 ref_clk = ~ref_clk;
   // Oscillator levels: rc toggles every cycle, the crystal has an eight-cycle period.
   always @(posedge ref_clk) begin
      div_ff <= div_ff + 3'h1;
      rc_clk_in <= ~rc_clk_in;
      xtal_clk_in <= div_ff[2];
   end
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         test_done;
      end
   end
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   task wr(input [31:0] a, input [31:0] d, input [3:0] st, input [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge ref_clk);
      while (s_axi_bvalid !== 1'b1) begin
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         @(posedge ref_clk);
      end
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task rd(input [31:0] a, input [31:0] exp, input [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge ref_clk);
      while (s_axi_rvalid !== 1'b1) begin
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         @(posedge ref_clk);
      end
      chk("rdata", s_axi_rdata, exp);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task t_reset;
      integer g;
      rd(32'h0, 32'h19, 2'h0);
      rd(32'h4, 32'h01, 2'h0);
      rd(32'h8, 32'h00, 2'h0);
      rd(32'hc, 32'h09, 2'h0);
      chk("rc_run", rc_osc_run, 32'h1);
      chk("xtal_run", crystal_osc_run, 32'h0);
      chk("warming", crystal_warming_flag, 32'h1);
      g = 0;
      repeat (8) begin
         @(posedge ref_clk);
         g = g + rc_clk_gated;
      end
      chk("rc_pass", g, 32'h4);
      $display("test reset done");
   endtask
   task t_bus;
      wr(32'h4, 32'h1a, 4'hf, 2'h0);
      tick(3);
      chk("range", rc_range_select, 32'h1);
      chk("coarse", rc_coarse_trim, 32'ha);
      wr(32'h8, 32'hffffffff, 4'hf, 2'h0);
      wr(32'h8, 32'h15, 4'he, 2'h0);
      rd(32'h8, 32'h3f, 2'h0);
      chk("fine", rc_fine_trim, 32'h3f);
      wr(32'h4, 32'h0, 4'hf, 2'h0);
      rd(32'h4, 32'h0, 2'h0);
      chk("coarse0", rc_coarse_trim, 32'h0);
      wr(32'h10, 32'h3, 4'hf, 2'h2);
      rd(32'h10, 32'h0, 2'h2);
      wr(32'hc, 32'hf, 4'hf, 2'h0);
      rd(32'hc, 32'h09, 2'h0);
      $display("test bus done");
   endtask
   task t_crystal;
      integer n, g;
      wr(32'h0, 32'h13, 4'hf, 2'h0);
      tick(3);
      chk("xtal_run", crystal_osc_run, 32'h1);
      chk("forced", rc_forced_select, 32'h0);
      n = 0;
      g = 0;
      while (crystal_warming_flag === 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n = n + 1;
         g = g + xtal_clk_gated;
      end
      chk("masked", g, 32'h0);
      chk("warm_len", n >= 8 * W - 16 && n <= 8 * W + 16, 32'h1);
      chk("warm_clear", crystal_warming_flag, 32'h0);
      tick(20);
      g = 0;
      repeat (16) begin
         @(posedge ref_clk);
         g = g + xtal_clk_gated;
      end
      chk("xtal_pulses", g, 32'h8);
      wr(32'h0, 32'h1b, 4'hf, 2'h0);
      rd(32'h0, 32'h13, 2'h0);
      wr(32'h0, 32'h12, 4'hf, 2'h0);
      tick(3);
      chk("rc_off", rc_osc_run, 32'h0);
      chk("bias_kept", rc_bias_on, 32'h1);
      g = 0;
      repeat (8) begin
         @(posedge ref_clk);
         g = g + rc_clk_gated;
      end
      chk("rc_gated", g, 32'h0);
      wr(32'h0, 32'h02, 4'hf, 2'h0);
      tick(3);
      chk("bias_off", rc_bias_on, 32'h0);
      wr(32'h0, 32'h11, 4'hf, 2'h0);
      tick(3);
      chk("xtal_off", crystal_osc_run, 32'h0);
      chk("rewarm", crystal_warming_flag, 32'h1);
      $display("test crystal done");
   endtask
   task t_sleep;
      wr(32'h0, 32'h13, 4'hf, 2'h0);
      tick(3);
      sleep_mode <= 1'b1;
      tick(4);
      chk("rc_sleep", rc_osc_run, 32'h0);
      chk("xtal_sleep", crystal_osc_run, 32'h0);
      chk("warm_sleep", crystal_warming_flag, 32'h1);
      chk("bias_sleep", rc_bias_on, 32'h1);
      wr(32'h0, 32'h02, 4'hf, 2'h0);
      rd(32'h0, 32'h19, 2'h0);
      sleep_mode <= 1'b0;
      tick(3);
      chk("rc_wake", rc_osc_run, 32'h1);
      chk("forced_wake", rc_forced_select, 32'h1);
      $display("test sleep done");
   endtask
   task t_pin;
      wr(32'h4, 32'h05, 4'hf, 2'h0);
      wr(32'h8, 32'h2a, 4'hf, 2'h0);
      wr(32'h0, 32'h03, 4'hf, 2'h0);
      tick(3);
      external_reset_pin_n <= 1'b0;
      tick(3);
      chk("xtal_pin", crystal_osc_run, 32'h0);
      chk("warm_pin", crystal_warming_flag, 32'h1);
      wr(32'h4, 32'h1f, 4'hf, 2'h0);
      external_reset_pin_n <= 1'b1;
      tick(3);
      rd(32'h4, 32'h01, 2'h0);
      rd(32'h8, 32'h00, 2'h0);
      rd(32'h0, 32'h19, 2'h0);
      chk("rc_pin", rc_osc_run, 32'h1);
      $display("test pin done");
   endtask
   initial begin
      tick(20);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset;
      t_bus;
      t_crystal;
      t_sleep;
      t_pin;
      test_done;
   end
endmodule
